/* File: design/sysflg_pkg.sv */
// Shared constants for the system status flag bank.
package sysflg_pkg;
  // Flag space and bit positions.
  localparam int NUM_BITS     = 128;
  localparam int IDX_W        = 7;
  localparam int IDX_FIRST    = 0;
  localparam int IDX_FINAL    = 1;
  localparam int IDX_T_HUND   = 2;
  localparam int IDX_T_TENTH  = 3;
  localparam int IDX_TICK_ONE_SECOND    = 4;
  localparam int IDX_T_MIN    = 5;
  localparam int IDX_ON       = 6;
  localparam int IDX_OFF      = 7;
  localparam int IDX_CTL_FULL = 8;
  localparam int IDX_IO_FULL  = 9;
  localparam int IDX_BG       = 12;
  localparam int IDX_OVR      = 33;
  localparam int IDX_APP      = 34;
  localparam int IDX_CFG      = 40;
  localparam int IDX_HW       = 41;
  localparam int IDX_NOPROG   = 72;
  localparam int IDX_RAM      = 73;
  localparam int IDX_PWD      = 74;
  localparam int IDX_STORE    = 77;
  localparam int IDX_ANY      = 104;
  localparam int IDX_CTL      = 105;
  localparam int IDX_IOF      = 106;
  localparam int IDX_CTL_NE   = 107;
  localparam int IDX_IO_NE    = 108;
  // Reset values.
  localparam logic [NUM_BITS-1:0] FLAGS_RST = '0;
  localparam logic [31:0]         CNT_RST   = 32'h0000_0000;
  // Tick periods and the clock rate.
  localparam int CLK_KHZ       = 25000;
  localparam int TICK_HUND_MS  = 10;
  localparam int TICK_TENTH_MS = 100;
  localparam int TICK_SEC_MS   = 1000;
  localparam int TICK_MIN_MS   = 60000;
  localparam int HUND_CYC      = TICK_HUND_MS * CLK_KHZ;
  localparam int TENTH_CYC     = TICK_TENTH_MS * CLK_KHZ;
  localparam int SEC_CYC       = TICK_SEC_MS * CLK_KHZ;
  localparam int MIN_CYC       = TICK_MIN_MS * CLK_KHZ;
  // Default fault log depth.
  localparam int LOG_DEPTH     = 16;
endpackage

/* File: design/sysflg_tick.sv */
// Free-running square-wave tick contact.
`timescale 1ns/1ps
`default_nettype none
module sysflg_tick import sysflg_pkg::*; #(
  parameter int PERIOD = HUND_CYC
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Tick contact.
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        out;
  } sysflg_tick_t;

  sysflg_tick_t st_ff;
  sysflg_tick_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (st_ff.cnt >= 32'(PERIOD / 2 - 1)) begin
      nxt_st.cnt = CNT_RST;
      nxt_st.out = ~st_ff.out;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.out;
endmodule // sysflg_tick
`default_nettype wire

/* File: design/sysflg_log.sv */
// Occupancy tracker for one fault table.
`timescale 1ns/1ps
`default_nettype none
module sysflg_log import sysflg_pkg::*; #(
  parameter int DEPTH = LOG_DEPTH
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Table events.
  input  wire logic add,
  input  wire logic remove,
  input  wire logic clear,
  // Occupancy flags.
  output logic      full,
  output logic      nonempty
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } sysflg_log_t;

  sysflg_log_t st_ff;
  sysflg_log_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      // An add in the clearing cycle lands in the emptied table.
      nxt_st.cnt = CW'(add);
    end else if (remove && !add && st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - CW'(1);
    end else if (add && !remove && st_ff.cnt != CW'(DEPTH)) begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign full     = (st_ff.cnt == CW'(DEPTH));
  assign nonempty = (st_ff.cnt != '0);
endmodule // sysflg_log
`default_nettype wire

/* File: design/sysflg_bank.sv */
// System status and fault summary flag bank.
`timescale 1ns/1ps
`default_nettype none
module sysflg_bank import sysflg_pkg::*; #(
  parameter int HUND_P  = HUND_CYC,
  parameter int TENTH_P = TENTH_CYC,
  parameter int SEC_P   = SEC_CYC,
  parameter int MIN_P   = MIN_CYC,
  parameter int DEPTH   = LOG_DEPTH
) (
  // Clock and reset.
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  // Sweep and mode control.
  input  wire logic                sweep_start,
  input  wire logic                run_mode,
  input  wire logic                last_sweep_req,
  input  wire logic [31:0]         sweep_limit,
  input  wire logic                run_request,
  input  wire logic                program_present,
  input  wire logic                bg_check_active,
  // Fault table events.
  input  wire logic                ctl_log_add,
  input  wire logic                ctl_log_remove,
  input  wire logic                ctl_log_clear,
  input  wire logic                io_log_add,
  input  wire logic                io_log_remove,
  input  wire logic                io_log_clear,
  input  wire logic                fault_fatal,
  // Fault sources.
  input  wire logic                app_fault,
  input  wire logic                powerup_check_done,
  input  wire logic                mismatch_found,
  input  wire logic                ram_corrupt_found,
  input  wire logic                cpu_hw_fault,
  input  wire logic                password_violation,
  input  wire logic                password_granted,
  input  wire logic                store_failed,
  input  wire logic                store_ok,
  // Application clear of one flag.
  input  wire logic                app_clear,
  input  wire logic [IDX_W-1:0]    app_clear_idx,
  // Flag space and stop request.
  output logic [NUM_BITS-1:0]      status_bits,
  output logic                     stop_fault_req
);
  typedef struct packed {
    logic [NUM_BITS-1:0] live;
    logic [NUM_BITS-1:0] shown;
    logic [31:0]         sweep_cyc;
    logic                ran;
    logic                prev_run;
    logic                run_rise;
    logic                last_pend;
    logic                ctl_cleared;
    logic                io_cleared;
    logic                stop;
  } sysflg_bank_t;

  sysflg_bank_t st_ff;
  sysflg_bank_t nxt_st;
  logic [1:0]   rst_sync_ff;
  logic         rst_n;
  logic         t_hund;
  logic         t_tenth;
  logic         tick_one_second;
  logic         t_min;
  logic         ctl_full;
  logic         ctl_ne;
  logic         io_full;
  logic         io_ne;
  logic         fatal_now;
  logic         run_entry;

  // Release of the asynchronous reset is synchronised here.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  sysflg_tick #(.PERIOD(HUND_P)) u_hund (
    .ref_clk (ref_clk), .rst_n (rst_n), .tick (t_hund));
  sysflg_tick #(.PERIOD(TENTH_P)) u_tenth (
    .ref_clk (ref_clk), .rst_n (rst_n), .tick (t_tenth));
  sysflg_tick #(.PERIOD(SEC_P)) u_sec (
    .ref_clk (ref_clk), .rst_n (rst_n), .tick (tick_one_second));
  sysflg_tick #(.PERIOD(MIN_P)) u_min (
    .ref_clk (ref_clk), .rst_n (rst_n), .tick (t_min));

  sysflg_log #(.DEPTH(DEPTH)) u_ctl_log (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .add      (ctl_log_add),
    .remove   (ctl_log_remove),
    .clear    (ctl_log_clear),
    .full     (ctl_full),
    .nonempty (ctl_ne));
  sysflg_log #(.DEPTH(DEPTH)) u_io_log (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .add      (io_log_add),
    .remove   (io_log_remove),
    .clear    (io_log_clear),
    .full     (io_full),
    .nonempty (io_ne));

  // Faults that halt the controller.
  assign fatal_now = fault_fatal | cpu_hw_fault | store_failed
                   | (powerup_check_done & mismatch_found)
                   | (powerup_check_done & ram_corrupt_found)
                   | (run_request & ~program_present);
  assign run_entry = run_mode & ~st_ff.prev_run;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev_run = run_mode;
    if (st_ff.sweep_cyc != 32'hFFFF_FFFF) begin
      nxt_st.sweep_cyc = st_ff.sweep_cyc + 32'h0000_0001;
    end
    if (run_entry) begin
      nxt_st.run_rise = 1'b1;
    end
    if (last_sweep_req) begin
      nxt_st.last_pend = 1'b1;
    end
    if (app_clear) begin
      nxt_st.live[app_clear_idx] = 1'b0;
    end
    if (ctl_log_clear) begin
      nxt_st.live[IDX_CTL] = 1'b0;
      nxt_st.ctl_cleared   = 1'b1;
      nxt_st.stop          = 1'b0;
    end
    if (io_log_clear) begin
      nxt_st.live[IDX_IOF] = 1'b0;
      nxt_st.io_cleared    = 1'b1;
    end
    if (nxt_st.ctl_cleared && nxt_st.io_cleared) begin
      nxt_st.live[IDX_ANY] = 1'b0;
    end
    if (powerup_check_done) begin
      nxt_st.live[IDX_RAM] = ram_corrupt_found;
      nxt_st.live[IDX_CFG] = mismatch_found;
    end
    if (password_granted) begin
      nxt_st.live[IDX_PWD] = 1'b0;
    end
    if (store_ok) begin
      nxt_st.live[IDX_STORE] = 1'b0;
    end
    if (run_entry && program_present) begin
      nxt_st.live[IDX_NOPROG] = 1'b0;
    end
    if (sweep_start) begin
      nxt_st.sweep_cyc = CNT_RST;
      nxt_st.run_rise  = 1'b0;
      nxt_st.last_pend = 1'b0;
      nxt_st.live[IDX_FIRST] = run_mode & ~st_ff.ran;
      nxt_st.ran             = run_mode;
      nxt_st.live[IDX_FINAL] = ~(st_ff.last_pend | last_sweep_req);
      if (st_ff.run_rise || run_entry) begin
        nxt_st.live[IDX_APP] = 1'b0;
        nxt_st.live[IDX_OVR] = 1'b0;
      end else if (run_mode && st_ff.ran) begin
        nxt_st.live[IDX_OVR] = (st_ff.sweep_cyc > sweep_limit);
      end
    end
    if (!run_mode) begin
      nxt_st.ran = 1'b0;
    end
    // Setting events win over any clear in the same cycle.
    if (app_fault) begin
      nxt_st.live[IDX_APP] = 1'b1;
    end
    if (cpu_hw_fault) begin
      nxt_st.live[IDX_HW] = 1'b1;
    end
    if (run_request && !program_present) begin
      nxt_st.live[IDX_NOPROG] = 1'b1;
    end
    if (password_violation) begin
      nxt_st.live[IDX_PWD] = 1'b1;
    end
    if (store_failed) begin
      nxt_st.live[IDX_STORE] = 1'b1;
    end
    if (ctl_log_add) begin
      nxt_st.live[IDX_CTL] = 1'b1;
      nxt_st.ctl_cleared   = 1'b0;
    end
    if (io_log_add) begin
      nxt_st.live[IDX_IOF] = 1'b1;
      nxt_st.io_cleared    = 1'b0;
    end
    if (ctl_log_add || io_log_add) begin
      nxt_st.live[IDX_ANY] = 1'b1;
    end
    if (fatal_now) begin
      nxt_st.stop = 1'b1;
    end
    // The hardware fault bit may not be cleared by the program.
    if (st_ff.live[IDX_HW]) begin
      nxt_st.live[IDX_HW] = 1'b1;
    end
    if (sweep_start) begin
      nxt_st.shown = nxt_st.live;
    end else if (app_clear) begin
      nxt_st.shown[app_clear_idx] = st_ff.shown[app_clear_idx]
                                  & nxt_st.live[app_clear_idx];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{live: FLAGS_RST | (NUM_BITS'(1) << IDX_FINAL),
                 shown: FLAGS_RST | (NUM_BITS'(1) << IDX_FINAL),
                 sweep_cyc: CNT_RST,
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    status_bits               = st_ff.shown;
    status_bits[IDX_T_HUND]   = t_hund;
    status_bits[IDX_T_TENTH]  = t_tenth;
    status_bits[IDX_TICK_ONE_SECOND]    = tick_one_second;
    status_bits[IDX_T_MIN]    = t_min;
    status_bits[IDX_ON]       = 1'b1;
    status_bits[IDX_OFF]      = 1'b0;
    status_bits[IDX_CTL_FULL] = ctl_full;
    status_bits[IDX_IO_FULL]  = io_full;
    status_bits[IDX_BG]       = bg_check_active;
    status_bits[IDX_CTL_NE]   = ctl_ne;
    status_bits[IDX_IO_NE]    = io_ne;
  end
  assign stop_fault_req = st_ff.stop;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_first_once: assert property (
    sweep_start && st_ff.ran && run_mode |=> !status_bits[IDX_FIRST])
    else $error("first sweep flag set on a later sweep");
  a_final_drop: assert property (
    sweep_start && st_ff.last_pend |=> !status_bits[IDX_FINAL])
    else $error("final sweep flag not dropped");
  a_full_implies: assert property (
    status_bits[IDX_CTL_FULL] |-> status_bits[IDX_CTL_NE])
    else $error("full table reported empty");
  a_hw_sticky: assert property (
    st_ff.live[IDX_HW] |=> st_ff.live[IDX_HW])
    else $error("hardware fault flag cleared");
  a_hw_shown: assert property (
    st_ff.shown[IDX_HW] |=> st_ff.shown[IDX_HW])
    else $error("shown hardware fault flag cleared");
  a_overrun_set: assert property (
    sweep_start && run_mode && st_ff.ran && !st_ff.run_rise
      && st_ff.sweep_cyc > sweep_limit |=> st_ff.live[IDX_OVR])
    else $error("overrun not flagged");
  a_noprog_set: assert property (
    run_request && !program_present |=> st_ff.live[IDX_NOPROG])
    else $error("missing program not flagged");
  a_fatal_stop: assert property (
    fatal_now |=> stop_fault_req)
    else $error("fatal fault did not force stop");
  a_snap_stable: assert property (
    !sweep_start && !app_clear |=> $stable(st_ff.shown))
    else $error("shown flags changed mid sweep");
  a_app_clear: assert property (
    $fell(st_ff.live[IDX_APP]) |-> $past(app_clear)
      || $past(sweep_start && (st_ff.run_rise || run_entry)))
    else $error("application fault cleared without cause");
  a_any_set: assert property (
    ctl_log_add || io_log_add |=> st_ff.live[IDX_ANY])
    else $error("any fault flag not set");
endmodule // sysflg_bank
`default_nettype wire

/* File: sim/sysflg_bank_test.sv */
// Self-checking testbench for the system status flag bank.
`timescale 1ns/1ps
`default_nettype none
module sysflg_bank_test import sysflg_pkg::*;;
  localparam int HP  = 8;
  localparam int TP  = 16;
  localparam int SP  = 32;
  localparam int MP  = 64;
  localparam int DP  = 4;
  localparam int SW  = 17;
  localparam int LSR = 16;
  localparam int RRQ = 15;
  localparam int ACL = 14;
  localparam int PUD = 8;
  localparam int APP = 7;
  localparam int FF  = 6;
  localparam int HW  = 9;

  logic                ref_clk;
  logic                reset_n;
  logic                run_mode;
  logic                program_present;
  logic                bg_check_active;
  logic                mismatch_found;
  logic                ram_corrupt_found;
  logic [31:0]         sweep_limit;
  logic [IDX_W-1:0]    app_clear_idx;
  logic [17:0]         ev;
  logic [NUM_BITS-1:0] status_bits;
  logic [NUM_BITS-1:0] want;
  logic                stop_fault_req;
  int                  num_errors;
  int                  checks;
  int                  t;

  sysflg_bank #(
    .HUND_P (HP),
    .TENTH_P(TP),
    .SEC_P  (SP),
    .MIN_P  (MP),
    .DEPTH  (DP)
  ) u_dut (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .sweep_start       (ev[SW]),
    .run_mode          (run_mode),
    .last_sweep_req    (ev[LSR]),
    .sweep_limit       (sweep_limit),
    .run_request       (ev[RRQ]),
    .program_present   (program_present),
    .bg_check_active   (bg_check_active),
    .ctl_log_add       (ev[0]),
    .ctl_log_remove    (ev[1]),
    .ctl_log_clear     (ev[2]),
    .io_log_add        (ev[3]),
    .io_log_remove     (ev[4]),
    .io_log_clear      (ev[5]),
    .fault_fatal       (ev[FF]),
    .app_fault         (ev[APP]),
    .powerup_check_done(ev[PUD]),
    .mismatch_found    (mismatch_found),
    .ram_corrupt_found (ram_corrupt_found),
    .cpu_hw_fault      (ev[HW]),
    .password_violation(ev[10]),
    .password_granted  (ev[11]),
    .store_failed      (ev[12]),
    .store_ok          (ev[13]),
    .app_clear         (ev[ACL]),
    .app_clear_idx     (app_clear_idx),
    .status_bits       (status_bits),
    .stop_fault_req    (stop_fault_req)
  );

  task automatic close_out();
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic pulse(input int b, input int n = 1);
    @(posedge ref_clk);
    #1 ev[b] = 1'b1;
    repeat (n) @(posedge ref_clk);
    #1 ev[b] = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic sweep();
    pulse(SW);
    idle(1);
  endtask

  task automatic tk(input int idx, input int p);
    int   r1;
    int   r2;
    int   n;
    logic pv;
    r1 = -1;
    r2 = -1;
    pv = status_bits[idx];
    for (n = 0; n < 3 * p; n++) begin
      idle(1);
      if (status_bits[idx] === 1'b1 && pv === 1'b0) begin
        if (r1 < 0) r1 = n;
        else if (r2 < 0) r2 = n;
      end
      pv = status_bits[idx];
    end
    chk(r2 - r1, p);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    #(40 * 8000);
    num_errors++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    ev = '0;
    run_mode = 1'b0;
    program_present = 1'b1;
    bg_check_active = 1'b0;
    mismatch_found = 1'b0;
    ram_corrupt_found = 1'b0;
    sweep_limit = 32'h0000_0014;
    app_clear_idx = '0;
    num_errors = 0;
    checks = 0;
    repeat (5) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    idle(3);
    want = '0;
    want[IDX_FINAL] = 1'b1;
    want[IDX_ON] = 1'b1;
    chk(status_bits, want);
    chk(stop_fault_req, 1'b0);
    bg_check_active = 1'b1;
    idle(1);
    chk(status_bits[IDX_BG], 1'b1);
    bg_check_active = 1'b0;
    idle(1);
    chk(status_bits[IDX_BG], 1'b0);
    tk(IDX_T_HUND, HP);
    tk(IDX_T_TENTH, TP);
    tk(IDX_TICK_ONE_SECOND, SP);
    tk(IDX_T_MIN, MP);
    // Application fault and program clear.
    pulse(APP);
    idle(2);
    chk(status_bits[IDX_APP], 1'b0);
    sweep();
    sweep();
    chk(status_bits[IDX_APP], 1'b1);
    app_clear_idx = IDX_W'(IDX_APP);
    pulse(ACL);
    sweep();
    chk(status_bits[IDX_APP], 1'b0);
    pulse(APP);
    sweep();
    chk(status_bits[IDX_APP], 1'b1);
    pulse(HW);
    sweep();
    app_clear_idx = IDX_W'(IDX_HW);
    pulse(ACL);
    chk(status_bits[IDX_HW], 1'b1);
    sweep();
    chk(status_bits[IDX_HW], 1'b1);
    chk(stop_fault_req, 1'b1);
    // Flags with their own set and clear events.
    for (t = 0; t < 2; t++) begin
      pulse(10 + 2 * t);
      sweep();
      chk(status_bits[t ? IDX_STORE : IDX_PWD], 1'b1);
      pulse(11 + 2 * t);
      sweep();
      chk(status_bits[t ? IDX_STORE : IDX_PWD], 1'b0);
    end
    mismatch_found = 1'b1;
    ram_corrupt_found = 1'b1;
    pulse(PUD);
    sweep();
    mismatch_found = 1'b0;
    ram_corrupt_found = 1'b0;
    chk(status_bits[IDX_CFG], 1'b1);
    chk(status_bits[IDX_RAM], 1'b1);
    pulse(APP);
    sweep();
    chk(status_bits[IDX_CFG], 1'b1);
    pulse(PUD);
    sweep();
    chk(status_bits[IDX_CFG], 1'b0);
    chk(status_bits[IDX_RAM], 1'b0);
    pulse(2);
    chk(stop_fault_req, 1'b0);
    pulse(FF);
    idle(1);
    chk(stop_fault_req, 1'b1);
    // Both fault tables: fill, refuse, remove, clear.
    for (t = 0; t < 2; t++) begin
      pulse(3 * t, 5);
      chk(status_bits[IDX_CTL_FULL + t], 1'b1);
      chk(status_bits[IDX_CTL_NE + t], 1'b1);
      pulse(3 * t + 1);
      chk(status_bits[IDX_CTL_FULL + t], 1'b0);
      pulse(3 * t + 1, 2);
      chk(status_bits[IDX_CTL_NE + t], 1'b1);
      sweep();
      chk(status_bits[IDX_CTL + t], 1'b1);
      chk(status_bits[IDX_ANY], 1'b1);
      pulse(3 * t + 2);
      sweep();
      chk(status_bits[IDX_CTL_NE + t], 1'b0);
      chk(status_bits[IDX_CTL + t], 1'b0);
      chk(status_bits[IDX_ANY], t == 0);
      chk(stop_fault_req, 1'b0);
    end
    // Missing program, then run entry with sweep timing.
    program_present = 1'b0;
    pulse(RRQ);
    sweep();
    chk(status_bits[IDX_NOPROG], 1'b1);
    program_present = 1'b1;
    run_mode = 1'b1;
    sweep();
    chk(status_bits[IDX_FIRST], 1'b1);
    chk(status_bits[IDX_APP], 1'b0);
    chk(status_bits[IDX_NOPROG], 1'b0);
    sweep();
    chk(status_bits[IDX_FIRST], 1'b0);
    idle(30);
    sweep();
    chk(status_bits[IDX_OVR], 1'b1);
    sweep();
    chk(status_bits[IDX_OVR], 1'b0);
    chk(status_bits[IDX_FINAL], 1'b1);
    pulse(LSR);
    sweep();
    chk(status_bits[IDX_FINAL], 1'b0);
    sweep();
    chk(status_bits[IDX_FINAL], 1'b1);
    idle(30);
    sweep();
    chk(status_bits[IDX_OVR], 1'b1);
    run_mode = 1'b0;
    sweep();
    run_mode = 1'b1;
    sweep();
    chk(status_bits[IDX_OVR], 1'b0);
    chk(status_bits[IDX_FIRST], 1'b1);
    chk(status_bits[IDX_HW], 1'b1);
    close_out();
  end
endmodule // sysflg_bank_test
`default_nettype wire
